/* File: design/pin_filter.sv */
// Three-stage synchroniser and agreement filter for asynchronous pins.
// Assumes inputs may change at any time relative to the clock.
`timescale 1ns/1ps
module pin_filter
    import sar_read_pkg::*;
#(
    parameter int                WIDTH   = PINS_W,
    parameter logic [WIDTH-1:0]  RST_VAL = '0
)(
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Raw and filtered levels
    input  wire logic [WIDTH-1:0] raw_in,
    output logic      [WIDTH-1:0] filt_out
);

    // Refused at elaboration: an empty chain has nothing to filter
    if (WIDTH < 1)
    begin : g_bad_width
        $error("pin_filter needs at least one bit");
    end

    ////////////////////////////////////////////////////////////////////////
    // One chain per bit; stage one feeds stage two only
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic s1_ff;
            logic s2_ff;
            logic s3_ff;
            logic q_ff;
            always_ff @(posedge clk_in)
            begin
                if (rst_in)
                begin
                    s1_ff <= RST_VAL[i];
                    s2_ff <= RST_VAL[i];
                    s3_ff <= RST_VAL[i];
                    q_ff  <= RST_VAL[i];
                end
                else
                begin
                    s1_ff <= raw_in[i];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    // A change counts once two stages agree
                    if (s2_ff == s3_ff)
                        q_ff <= s3_ff;
                end
            end
            assign filt_out[i] = q_ff;
        end
    endgenerate

endmodule

/* File: design/sar_read_pkg.sv */
// Shared constants, types and register map of the converter read port.
// Assumes a single 125 MHz clock; used by every design file of the block.
package sar_read_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int CLK_MHZ       = 125;
    localparam int STS_MIN_NS    = 75;   // Status fall after data valid
    localparam int STS_MAX_NS    = 375;
    localparam int CONV_PULSE_NS = 25;   // Least low convert pulse
    localparam int STS_MIN_CYC   = (STS_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int STS_MAX_CYC   = (STS_MAX_NS * CLK_MHZ) / 1000;
    localparam int CONV_PULSE_CYC = (CONV_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int STS_DELAY_CYC = STS_MIN_CYC;
    localparam int CNT_W         = 16;

    ////////////////////////////////////////////////////////////////////////
    // Result layout
    localparam int RES_W  = 12;
    localparam int NIB_W  = 4;
    localparam int LO_LSB = 0;
    localparam int MID_LSB = 4;
    localparam int HI_LSB = 8;

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam logic [7:0] REG_STATE   = 8'h00;
    localparam logic [7:0] REG_RESULT  = 8'h04;
    localparam logic [7:0] REG_IRQ_STS = 8'h08;
    localparam logic [7:0] REG_IRQ_CLR = 8'h0c;
    localparam logic [7:0] REG_IRQ_EN  = 8'h10;
    localparam int ADDR_W = 8;
    localparam int IRQ_W  = 2;
    localparam int IRQ_DONE    = 0;    // Conversion finished
    localparam int IRQ_IGNORED = 1;    // Convert request while busy
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    ////////////////////////////////////////////////////////////////////////
    // Control pins, kept together for the synchroniser
    typedef struct packed {
        logic cs_n;
        logic ce;
        logic byte_sel;
        logic rc_n;
        logic wide;
    } pins_t;
    localparam int PINS_W = 5;
    localparam pins_t PINS_IDLE = '{cs_n: 1'b1, ce: 1'b0, byte_sel: 1'b0,
                                    rc_n: 1'b1, wide: 1'b1};

    // Converter sequence states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_CONV   = 3'b010,
        ST_SETTLE = 3'b100
    } conv_state_t;

endpackage

/* File: design/sar_read_port.sv */
// Read, convert-control and status logic of a 12-bit sampling converter,
// with an AXI4-Lite register view and one level interrupt.
// Assumes control pins are asynchronous; SAMPLE_IN is same-clock logic.
//
// What this block does
// - Drive result bits 3..0 only while byte select is high.
// - Twelve-bit format: bits 7..4 show middle nibble for any byte select.
// - Bits 11..8 driven in 12-bit format; 8-bit only with byte low.
// - Status stays high during conversion, low once it completes.
// - Result latched valid first; status falls 75 to 375 ns later.
// - Falling convert strobe holds the input and starts converting.
// - While busy, result bus floats and convert requests are ignored.
// - Eight- or twelve-bit cycle; read whole word or left-justified bytes.
`timescale 1ns/1ps
module sar_read_port
    import sar_read_pkg::*;
#(
    parameter int CONV_CYCLES = 64     // Twelve-bit conversion length
)(
    // Clock and reset
    input  wire logic              CLOCK_IN,
    input  wire logic              RST_IN,
    // Control pins
    input  wire logic              CS_N_IN,
    input  wire logic              CE_IN,
    input  wire logic              BYTE_SEL_IN,
    input  wire logic              RC_N_IN,
    input  wire logic              WIDE_IN,
    // Sampled input word from the capacitor array
    input  wire logic [RES_W-1:0]  SAMPLE_IN,
    // Result bus and status pins
    output logic      [RES_W-1:0]  RESULT_OUT,
    output logic      [RES_W-1:0]  RESULT_OE_OUT,
    output logic                   STATUS_OUT,
    // AXI4-Lite write channels
    input  wire logic              AWVALID_IN,
    output logic                   AWREADY_OUT,
    input  wire logic [ADDR_W-1:0] AWADDR_IN,
    input  wire logic              WVALID_IN,
    output logic                   WREADY_OUT,
    input  wire logic [31:0]       WDATA_IN,
    input  wire logic [3:0]        WSTRB_IN,
    output logic                   BVALID_OUT,
    input  wire logic              BREADY_IN,
    output logic      [1:0]        BRESP_OUT,
    // AXI4-Lite read channels
    input  wire logic              ARVALID_IN,
    output logic                   ARREADY_OUT,
    input  wire logic [ADDR_W-1:0] ARADDR_IN,
    output logic                   RVALID_OUT,
    input  wire logic              RREADY_IN,
    output logic      [31:0]       RDATA_OUT,
    output logic      [1:0]        RRESP_OUT,
    // Interrupt
    output logic                   IRQ_OUT
);

    localparam int SHORT_CYCLES = (CONV_CYCLES * 8) / 12;

    // Refused at elaboration: the short cycle and the counter need room
    if (CONV_CYCLES < 12 || CONV_CYCLES >= (1 << CNT_W))
    begin : g_bad_conv
        $error("CONV_CYCLES out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    pins_t raw_pins;
    pins_t pins;
    assign raw_pins = '{cs_n: CS_N_IN, ce: CE_IN, byte_sel: BYTE_SEL_IN,
                        rc_n: RC_N_IN, wide: WIDE_IN};

    pin_filter #(
        .WIDTH   (PINS_W),
        .RST_VAL (PINS_IDLE)
    ) u_pins (
        .clk_in   (CLOCK_IN),
        .rst_in   (RST_IN),
        .raw_in   (raw_pins),
        .filt_out (pins)
    );

    ////////////////////////////////////////////////////////////////////////
    // Convert request: select low, enable high, strobe low, on any edge
    logic        req_now;
    logic        req_ff;
    logic        start;
    assign req_now = pins.ce && !pins.cs_n && !pins.rc_n;
    assign start   = req_now && !req_ff;

    always_ff @(posedge CLOCK_IN)
    begin
        if (RST_IN)
            req_ff <= 1'b0;
        else
            req_ff <= req_now;
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequence
    conv_state_t          state_ff;
    logic [CNT_W-1:0]     cnt_ff;
    logic [RES_W-1:0]     hold_ff;
    logic [RES_W-1:0]     result_ff;
    logic                 short_ff;
    logic                 done_ev;
    logic                 ignored_ev;
    logic                 busy;

    assign busy       = (state_ff != ST_IDLE);
    assign ignored_ev = start && busy;
    assign done_ev    = (state_ff == ST_SETTLE) && (cnt_ff == '0);

    // Sample is held at the start; a short cycle keeps only eight bits
    always_ff @(posedge CLOCK_IN)
    begin
        if (RST_IN)
        begin
            state_ff  <= ST_IDLE;
            cnt_ff    <= '0;
            hold_ff   <= '0;
            result_ff <= '0;
            short_ff  <= 1'b0;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        hold_ff  <= SAMPLE_IN;
                        short_ff <= pins.byte_sel;
                        cnt_ff   <= pins.byte_sel ?
                            CNT_W'(SHORT_CYCLES - 1) :
                            CNT_W'(CONV_CYCLES - 1);
                        state_ff <= ST_CONV;
                    end
                end
                ST_CONV:
                begin
                    if (cnt_ff == '0)
                    begin
                        // Data latched before status may fall
                        result_ff <= short_ff ?
                            {hold_ff[RES_W-1:MID_LSB], {NIB_W{1'b0}}} :
                            hold_ff;
                        cnt_ff    <= CNT_W'(STS_DELAY_CYC - 1);
                        state_ff  <= ST_SETTLE;
                    end
                    else
                        cnt_ff <= cnt_ff - CNT_W'(1);
                end
                ST_SETTLE:
                begin
                    if (cnt_ff == '0)
                        state_ff <= ST_IDLE;
                    else
                        cnt_ff <= cnt_ff - CNT_W'(1);
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status and result bus drivers, all registered
    logic rd_en;
    assign rd_en = pins.ce && !pins.cs_n && pins.rc_n && !busy;

    always_ff @(posedge CLOCK_IN)
    begin
        if (RST_IN)
        begin
            STATUS_OUT    <= 1'b0;
            RESULT_OUT    <= '0;
            RESULT_OE_OUT <= '0;
        end
        else
        begin
            // Status follows the sequence; ST_SETTLE keeps it high for STS_DELAY_CYC clocks
            // after the latch, so data always leads status
            STATUS_OUT <= (state_ff == ST_CONV) ||
                          ((state_ff == ST_SETTLE) && (cnt_ff != '0))
                          || (start && !busy);
            RESULT_OUT[LO_LSB +: NIB_W]  <= result_ff[LO_LSB +: NIB_W];
            RESULT_OUT[HI_LSB +: NIB_W]  <= result_ff[HI_LSB +: NIB_W];
            RESULT_OUT[MID_LSB +: NIB_W] <=
                (!pins.wide && pins.byte_sel) ? '0 :
                result_ff[MID_LSB +: NIB_W];
            RESULT_OE_OUT[LO_LSB +: NIB_W] <=
                {NIB_W{rd_en && pins.byte_sel}};
            RESULT_OE_OUT[MID_LSB +: NIB_W] <= {NIB_W{rd_en}};
            RESULT_OE_OUT[HI_LSB +: NIB_W] <=
                {NIB_W{rd_en && (pins.wide || !pins.byte_sel)}};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path: address and data taken in either order
    logic              aw_held_ff;
    logic              w_held_ff;
    logic [ADDR_W-1:0] waddr_ff;
    logic [31:0]       wdata_ff;
    logic              wstrb0_ff;
    logic              commit;
    assign commit = aw_held_ff && w_held_ff && !BVALID_OUT;

    always_ff @(posedge CLOCK_IN)
    begin
        if (RST_IN)
        begin
            aw_held_ff  <= 1'b0;
            w_held_ff   <= 1'b0;
            waddr_ff    <= '0;
            wdata_ff    <= '0;
            wstrb0_ff   <= 1'b0;
            AWREADY_OUT <= 1'b0;
            WREADY_OUT  <= 1'b0;
            BVALID_OUT  <= 1'b0;
            BRESP_OUT   <= RESP_OKAY;
        end
        else
        begin
            if (AWVALID_IN && AWREADY_OUT)
            begin
                aw_held_ff  <= 1'b1;
                waddr_ff    <= AWADDR_IN;
                AWREADY_OUT <= 1'b0;
            end
            else if (!aw_held_ff && !BVALID_OUT)
                AWREADY_OUT <= 1'b1;
            if (WVALID_IN && WREADY_OUT)
            begin
                w_held_ff  <= 1'b1;
                wdata_ff   <= WDATA_IN;
                wstrb0_ff  <= WSTRB_IN[0];
                WREADY_OUT <= 1'b0;
            end
            else if (!w_held_ff && !BVALID_OUT)
                WREADY_OUT <= 1'b1;
            if (commit)
            begin
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
                BVALID_OUT <= 1'b1;
                BRESP_OUT  <= (waddr_ff == REG_IRQ_CLR ||
                               waddr_ff == REG_IRQ_EN ||
                               waddr_ff == REG_STATE ||
                               waddr_ff == REG_RESULT ||
                               waddr_ff == REG_IRQ_STS) ?
                              RESP_OKAY : RESP_SLVERR;
            end
            else if (BVALID_OUT && BREADY_IN)
                BVALID_OUT <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, enable and output; a new event beats a clear
    logic [IRQ_W-1:0] irq_sts_ff;
    logic [IRQ_W-1:0] irq_en_ff;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic             wr_lo;
    assign wr_lo   = commit && wstrb0_ff;
    assign irq_set = {ignored_ev, done_ev};
    assign irq_clr = (wr_lo && waddr_ff == REG_IRQ_CLR) ?
                     wdata_ff[IRQ_W-1:0] : '0;

    always_ff @(posedge CLOCK_IN)
    begin
        if (RST_IN)
        begin
            irq_sts_ff <= '0;
            irq_en_ff  <= '0;
            IRQ_OUT    <= 1'b0;
        end
        else
        begin
            irq_sts_ff <= (irq_sts_ff & ~irq_clr) | irq_set;
            if (wr_lo && waddr_ff == REG_IRQ_EN)
                irq_en_ff <= wdata_ff[IRQ_W-1:0];
            IRQ_OUT <= |(irq_sts_ff & irq_en_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path; unmapped addresses answer SLVERR with zero
    always_ff @(posedge CLOCK_IN)
    begin
        if (RST_IN)
        begin
            ARREADY_OUT <= 1'b0;
            RVALID_OUT  <= 1'b0;
            RDATA_OUT   <= '0;
            RRESP_OUT   <= RESP_OKAY;
        end
        else if (ARVALID_IN && ARREADY_OUT)
        begin
            ARREADY_OUT <= 1'b0;
            RVALID_OUT  <= 1'b1;
            RRESP_OUT   <= RESP_OKAY;
            case (ARADDR_IN)
                REG_STATE:   RDATA_OUT <= {30'h0, short_ff, busy};
                REG_RESULT:  RDATA_OUT <= {20'h0, result_ff};
                REG_IRQ_STS: RDATA_OUT <= {30'h0, irq_sts_ff};
                REG_IRQ_EN:  RDATA_OUT <= {30'h0, irq_en_ff};
                REG_IRQ_CLR: RDATA_OUT <= '0;   // Write-only, reads zero
                default:
                begin
                    RDATA_OUT <= '0;
                    RRESP_OUT <= RESP_SLVERR;
                end
            endcase
        end
        else if (RVALID_OUT && RREADY_IN)
            RVALID_OUT <= 1'b0;
        else if (!RVALID_OUT)
            ARREADY_OUT <= 1'b1;
    end

endmodule

/* File: verification/sar_ctrl_model.sv */
// Controller model: drives the five control pins of the read port.
// Assumes the bench calls its tasks; pins change just after a rising edge.
`timescale 1ns/1ps
module sar_ctrl_model
    import sar_read_pkg::*;
(
    // Clock
    input  wire logic             clk_in,
    // Result bus as seen by the controller
    input  wire logic [RES_W-1:0] res_in,
    input  wire logic [RES_W-1:0] oe_in,
    // Control pins
    output pins_t                 pins_out
);
    // Long enough to clear the pin filter and the output register
    localparam int HOLD = 8;
    initial pins_out = PINS_IDLE;

    // Start by enable rise, or by strobe fall with enable already high
    task automatic convert(input logic b, input logic w, input logic by_rc);
        @(posedge clk_in);
        pins_out <= '{cs_n: 1'b0, ce: by_rc, byte_sel: b, rc_n: by_rc,
                      wide: w};
        repeat (HOLD) @(posedge clk_in);
        pins_out.rc_n <= 1'b0;
        pins_out.ce   <= 1'b1;
        repeat (HOLD) @(posedge clk_in);
        pins_out <= PINS_IDLE;
    endtask

    // Read cycle; undriven bits are masked so a float never reads as data
    task automatic read(input logic b, input logic w,
                        output logic [RES_W-1:0] oe,
                        output logic [RES_W-1:0] d);
        @(posedge clk_in);
        pins_out <= '{cs_n: 1'b0, ce: 1'b1, byte_sel: b, rc_n: 1'b1,
                      wide: w};
        repeat (HOLD) @(posedge clk_in);
        oe = oe_in;
        d  = res_in & oe_in;
        pins_out <= PINS_IDLE;
    endtask
endmodule

/* File: verification/sar_read_chk.sv */
// Checker of the read port: bus drive, status and register bus timing.
// Sees only the top-level ports; bound into every read port instance.
`timescale 1ns/1ps
module sar_read_chk
    import sar_read_pkg::*;
#(
    parameter int CONV_CYCLES = 64
)(
    // Clock and reset
    input wire logic             CLOCK_IN,
    input wire logic             RST_IN,
    // Pins
    input wire logic [RES_W-1:0] RESULT_OUT,
    input wire logic [RES_W-1:0] RESULT_OE_OUT,
    input wire logic             STATUS_OUT,
    // Register bus
    input wire logic             AWVALID_IN,
    input wire logic             AWREADY_OUT,
    input wire logic             WVALID_IN,
    input wire logic             WREADY_OUT,
    input wire logic             BVALID_OUT,
    input wire logic             BREADY_IN,
    input wire logic [1:0]       BRESP_OUT,
    input wire logic             ARVALID_IN,
    input wire logic             ARREADY_OUT,
    input wire logic             RVALID_OUT,
    input wire logic             RREADY_IN,
    input wire logic [31:0]      RDATA_OUT
);
    // Longest conversion plus the status delay, with margin
    localparam int ST_MAX = CONV_CYCLES + 16;
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RST_IN);

    a_low_nib_gate: assert property (|RESULT_OE_OUT[3:0] |->
        &RESULT_OE_OUT[7:0]) else $error("low nibble driven alone");
    a_mid_zero_8b: assert property (&RESULT_OE_OUT[3:0] &&
        RESULT_OE_OUT[11:8] == 4'h0 |-> RESULT_OUT[7:4] == 4'h0)
        else $error("middle nibble not zero");
    a_busy_float: assert property (STATUS_OUT |->
        RESULT_OE_OUT == 12'h000) else $error("bus driven while busy");
    a_status_min: assert property ($rose(STATUS_OUT) |->
        STATUS_OUT[*8]) else $error("status dropped early");
    a_status_max: assert property ($rose(STATUS_OUT) |->
        ##[1:ST_MAX] !STATUS_OUT) else $error("status stuck high");
    a_fall_gap: assert property ($fell(STATUS_OUT) |->
        $past(STATUS_OUT, 10)) else $error("status fell too soon");
    a_b_answer: assert property (AWVALID_IN && AWREADY_OUT && WVALID_IN &&
        WREADY_OUT |-> ##2 BVALID_OUT) else $error("write answer late");
    a_b_stands: assert property (BVALID_OUT && !BREADY_IN |=>
        BVALID_OUT && $stable(BRESP_OUT)) else $error("bresp moved");
    a_r_stands: assert property (RVALID_OUT && !RREADY_IN |=>
        RVALID_OUT && $stable(RDATA_OUT)) else $error("rdata moved");
    a_ar_answer: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT)
        else $error("read answer late");
    a_aw_closes: assert property (AWVALID_IN && AWREADY_OUT |=>
        !AWREADY_OUT) else $error("aw ready stayed high");
endmodule

bind sar_read_port sar_read_chk #(.CONV_CYCLES(CONV_CYCLES)) chk (
    .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .RESULT_OUT(RESULT_OUT),
    .RESULT_OE_OUT(RESULT_OE_OUT), .STATUS_OUT(STATUS_OUT),
    .AWVALID_IN(AWVALID_IN), .AWREADY_OUT(AWREADY_OUT),
    .WVALID_IN(WVALID_IN), .WREADY_OUT(WREADY_OUT),
    .BVALID_OUT(BVALID_OUT), .BREADY_IN(BREADY_IN), .BRESP_OUT(BRESP_OUT),
    .ARVALID_IN(ARVALID_IN), .ARREADY_OUT(ARREADY_OUT),
    .RVALID_OUT(RVALID_OUT), .RREADY_IN(RREADY_IN), .RDATA_OUT(RDATA_OUT));

/* File: verification/sar_read_port_tb_top.sv */
// Self-checking bench of the converter read port: pins, status, registers.
// Assumes the controller model drives the pins and the bench the bus.
`timescale 1ns/1ps
module sar_read_port_tb_top
    import sar_read_pkg::*;
;
    localparam int CONV = 48;  // Short conversion keeps the run brief
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [7:0]  awa = '0, ara = '0;
    logic [31:0] wd = '0, rd;
    logic [11:0] smp = '0, res, oe;
    logic        awr, wr, bv, arr, rv, sts, irq;
    logic [1:0]  br, rr;
    pins_t       pins;
    int          fail_count = 0, samples_checked = 0;
    logic [31:0] seed = 32'h0001596a;

    always #4 clk = ~clk;

    sar_read_port #(.CONV_CYCLES(CONV)) uut (
        .CLOCK_IN(clk), .RST_IN(rst), .CS_N_IN(pins.cs_n), .CE_IN(pins.ce),
        .BYTE_SEL_IN(pins.byte_sel), .RC_N_IN(pins.rc_n),
        .WIDE_IN(pins.wide), .SAMPLE_IN(smp), .RESULT_OUT(res),
        .RESULT_OE_OUT(oe), .STATUS_OUT(sts), .AWVALID_IN(awv),
        .AWREADY_OUT(awr), .AWADDR_IN(awa), .WVALID_IN(wv),
        .WREADY_OUT(wr), .WDATA_IN(wd), .WSTRB_IN(4'hf), .BVALID_OUT(bv),
        .BREADY_IN(bry), .BRESP_OUT(br), .ARVALID_IN(arv),
        .ARREADY_OUT(arr), .ARADDR_IN(ara), .RVALID_OUT(rv),
        .RREADY_IN(rry), .RDATA_OUT(rd), .RRESP_OUT(rr), .IRQ_OUT(irq));

    sar_ctrl_model ctl (.clk_in(clk), .res_in(res), .oe_in(oe),
                        .pins_out(pins));

    ////////////////////////////////////////////////////////////////////////
    // Expectation helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [11:0] exp_oe(input logic w, input logic b);
        return {(w | ~b) ? 4'hf : 4'h0, 4'hf, b ? 4'hf : 4'h0};
    endfunction
    function automatic logic [11:0] exp_dat(input logic [11:0] v,
                                            input logic w, input logic b);
        return {v[11:8], (~w & b) ? 4'h0 : v[7:4], v[3:0]} & exp_oe(w, b);
    endfunction

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Register bus master; each channel released at its own handshake
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        @(posedge clk);
        awv <= 1'b1;
        awa <= a;
        wv  <= 1'b1;
        wd  <= d;
        bry <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge clk);
            aw_ok = aw_ok | awr;
            w_ok  = w_ok | wr;
            if (aw_ok) awv <= 1'b0;
            if (w_ok) wv <= 1'b0;
        end
        do @(posedge clk); while (!bv);
        bry <= 1'b0;
        check("bresp", br, RESP_OKAY);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge clk);
        arv <= 1'b1;
        ara <= a;
        rry <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rv);
        d = rd;
        r = rr;
        rry <= 1'b0;
    endtask

    // Bounded wait for a status level
    task automatic wait_sts(input logic lvl);
        int n;
        n = 0;
        while (sts !== lvl && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        check("status", sts, lvl);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: random conversions with corner samples first
    initial
    begin
        logic b;
        logic w;
        logic [11:0] v;
        logic [11:0] o;
        logic [11:0] d;
        logic [31:0] x;
        logic [1:0] r;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        axi_wr(REG_IRQ_EN, 32'h3);
        axi_rd(REG_IRQ_EN, x, r);
        check("irq_en", x, 32'h3);
        axi_rd(8'h14, x, r);
        check("unmapped", x, 32'h0);
        check("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
        for (int i = 0; i < 8; i++)
        begin
            x = rnd();
            b = x[0];
            w = x[1];
            v = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : x[13:2];
            smp <= v;
            ctl.convert(b, w, x[14]);
            wait_sts(1'b1);
            ctl.read(1'b1, 1'b1, o, d);
            check("busy oe", o, 12'h000);
            ctl.convert(~b, w, 1'b0);
            wait_sts(1'b0);
            // A short cycle leaves the low nibble cleared
            if (b) v[3:0] = 4'h0;
            axi_rd(REG_RESULT, x, r);
            check("result", x, {20'h0, v});
            axi_rd(REG_STATE, x, r);
            check("state", x, {30'h0, b, 1'b0});
            check("irq on", irq, 1'b1);
            axi_rd(REG_IRQ_STS, x, r);
            check("irq_sts", x, 32'h3);
            axi_wr(REG_IRQ_CLR, 32'h3);
            for (int k = 0; k < 4; k++)
            begin
                ctl.read(k[0], k[1], o, d);
                check("oe", o, exp_oe(k[1], k[0]));
                check("data", d, exp_dat(v, k[1], k[0]));
            end
            repeat (8) @(posedge clk);
            check("float", oe, 12'h000);
            check("irq off", irq, 1'b0);
            $display("test %0d done", i);
        end
        summarize();
    end

    // Watchdog: far beyond eight test rounds of about 130 cycles each
    initial
    begin
        repeat (30000) @(posedge clk);
        fail_count++;
        summarize();
    end
endmodule
